// ==== design/flash_sync_status_monitor.sv ====
// flash sync detection, flash timing and status indicators
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
module flash_sync_status_monitor
   import flash_sync_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // external sync pin
   input wire logic ext_sync_in,
   // flash trigger and indicators
   output logic flash_ff,
   output logic heartbeat_indicator,
   output logic external_sync_fault_indicator,
   output logic day_to_twilight_fault_indicator,
   output logic twilight_to_night_fault_indicator,
   output logic lamp_degradation_indicator,
   output logic sync_fault_indicator,
   output logic comm_fault_indicator
);
   localparam int unsigned PERIOD_CYC = SYNC_PERIOD_MS * MS_CYCLES;
   localparam int unsigned PMIN_CYC = (SYNC_PERIOD_MS - SYNC_TOL_MS) * MS_CYCLES;
   localparam int unsigned PMAX_CYC = (SYNC_PERIOD_MS + SYNC_TOL_MS) * MS_CYCLES;
   localparam int unsigned HIGH_CYC = SYNC_MIN_HIGH_MS * MS_CYCLES;
   localparam int unsigned LOST_CYC = SYNC_LOST_PERIODS * PERIOD_CYC;
   localparam int unsigned HB_CYC = HEARTBEAT_MS * MS_CYCLES;
   localparam int unsigned BLINK_CYC = BLINK_MS * MS_CYCLES;

   // width and period counters stop at all ones, so a stuck pin cannot wrap back into the window
   function automatic logic [31:0] sat_inc(input logic [31:0] v);
      return (v == 32'hffff_ffff) ? v : v + 32'h1;
   endfunction

   // pin synchroniser: stage 1 read only by stage 2
   logic s1_ff, s2_ff, s3_ff, sync_lvl_ff;
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         sync_lvl_ff <= 1'b0;
      end
      else
      begin
         s1_ff <= ext_sync_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff)
            sync_lvl_ff <= s3_ff;
      end
   end

   // registers
   logic [4:0] ctrl_ff;
   logic [4:0] fault_ff;
   logic [1:0] event_ff;
   logic [3:0] alarm_ff;
   logic [1:0] aol_ff;
   logic [31:0] hi_cnt_ff, per_cnt_ff, lost_cnt_ff, int_cnt_ff;
   logic [31:0] hb_cnt_ff, blink_cnt_ff;
   logic [4:0] cd_cnt_ff;
   logic sync_prev_ff, armed_ff, locked_ff, blink_ff;
   run_state_e state_ff;

   wire ext_en = ctrl_ff[CTRL_EXT_EN];
   wire forced = ctrl_ff[CTRL_FORCED];
   wire src_powered = ctrl_ff[CTRL_EXT_PWR];
   // a write lands only at the edge that completes the access
   wire wr = psel && penable && pready && pwrite;
   wire rd = psel && !penable && !pwrite;
   wire known = (paddr == ADDR_CTRL) || (paddr == ADDR_FAULT) || (paddr == ADDR_STATUS)
      || (paddr == ADDR_EVENT) || (paddr == ADDR_ALARM) || (paddr == ADDR_AOL);
   wire wr_ctrl = wr && paddr == ADDR_CTRL;
   wire wr_fault = wr && paddr == ADDR_FAULT;
   wire wr_event = wr && paddr == ADDR_EVENT;
   wire wr_alarm = wr && paddr == ADDR_ALARM;
   wire wr_aol = wr && paddr == ADDR_AOL;
   wire restart = wr_ctrl && pwdata[CTRL_RESTART];

   // sync pulse qualification
   wire sync_gated = sync_lvl_ff && ext_en;
   wire rise = sync_gated && !sync_prev_ff;
   wire fall = !sync_gated && sync_prev_ff;
   wire width_ok = hi_cnt_ff > HIGH_CYC;
   wire period_ok = per_cnt_ff >= PMIN_CYC && per_cnt_ff <= PMAX_CYC;
   wire ext_tick = rise && armed_ff && period_ok && locked_ff;
   wire lock_edge = rise && armed_ff && period_ok;
   wire lost_now = locked_ff && lost_cnt_ff >= LOST_CYC - 1;
   // internal rate keeps the established phase after loss when source powered
   wire int_tick = int_cnt_ff >= PERIOD_CYC - 1;
   // a missing edge while locked still flashes, at the late end of the window,
   // so a dropped pulse never leaves the tower dark
   wire fly_tick = int_cnt_ff >= PMAX_CYC - 1;
   // an unpowered source hands the timing back at once, not after the timeout
   wire use_ext = locked_ff && ext_en && src_powered;
   wire flash_tick = use_ext ? (ext_tick || fly_tick) : int_tick;
   wire sync_lost_ev = lost_now && src_powered;
   wire sync_alarm = ext_en && !src_powered;
   wire cfg_mismatch = (ext_en && !src_powered) || (!ext_en && sync_lvl_ff);
   wire aol_ok = pwdata[1:0] <= 2'(MAX_AOL - 1);

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync_prev_ff <= 1'b0;
         hi_cnt_ff <= '0;
         per_cnt_ff <= '0;
         armed_ff <= 1'b0;
         locked_ff <= 1'b0;
         lost_cnt_ff <= '0;
      end
      else
      begin
         sync_prev_ff <= sync_gated;
         // width counts only while the enabled pin stays high
         hi_cnt_ff <= rise ? 32'h0 : (sync_gated ? sat_inc(hi_cnt_ff) : hi_cnt_ff);
         per_cnt_ff <= rise ? 32'h1 : sat_inc(per_cnt_ff);
         if (rise)
            armed_ff <= 1'b0;
         else if (fall && width_ok)
            armed_ff <= 1'b1;
         if (!ext_en || lost_now)
            locked_ff <= 1'b0;
         else if (lock_edge)
            locked_ff <= 1'b1;
         lost_cnt_ff <= (lock_edge || !locked_ff) ? 32'h0 : lost_cnt_ff + 32'h1;
      end
   end

   // internal rate generator, realigned by each external flash
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         int_cnt_ff <= '0;
      else if (flash_tick || ext_tick)
         int_cnt_ff <= '0;
      else
         int_cnt_ff <= int_cnt_ff + 32'h1;
   end

   // restart sequencing: warm-up, countdown, run
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_ff <= ST_WARMUP;
         cd_cnt_ff <= '0;
      end
      else if (restart)
      begin
         state_ff <= ST_WARMUP;
         cd_cnt_ff <= '0;
      end
      else
      begin
         case (state_ff)
            ST_WARMUP:
               if (flash_tick)
                  state_ff <= ST_COUNTDOWN;
            ST_COUNTDOWN:
               if (flash_tick)
               begin
                  if (cd_cnt_ff == 5'(COUNTDOWN_FLASHES - 1))
                     state_ff <= ST_RUN;
                  cd_cnt_ff <= cd_cnt_ff + 5'h1;
               end
            ST_RUN: ;
            default: state_ff <= ST_WARMUP;
         endcase
      end
   end

   // registers: set wins over clear
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_ff <= CTRL_RESET;
         fault_ff <= '0;
         event_ff <= '0;
         alarm_ff <= '0;
         aol_ff <= '0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_ff <= {pwdata[CTRL_EXT_PWR], 1'b0, pwdata[CTRL_CFG_BAD:0]};
         if (wr_fault)
            fault_ff <= pwdata[4:0];
         if (wr_aol && aol_ok)
            aol_ff <= pwdata[1:0];
         event_ff <= (event_ff & ~(wr_event ? pwdata[1:0] : 2'h0))
            | {cfg_mismatch, sync_lost_ev};
         // restart does not touch the alarm log
         alarm_ff <= (alarm_ff & ~(wr_alarm ? pwdata[3:0] : 4'h0))
            | {fault_ff[FLT_LINK], fault_ff[FLT_PSU_PWR], sync_alarm,
               fault_ff[FLT_LAMP25]};
      end
   end

   // indicator timing
   wire hb_tick = hb_cnt_ff >= HB_CYC - 1;
   wire bl_tick = blink_cnt_ff >= BLINK_CYC - 1;
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hb_cnt_ff <= '0;
         blink_cnt_ff <= '0;
         blink_ff <= 1'b0;
         heartbeat_indicator <= 1'b0;
      end
      else
      begin
         hb_cnt_ff <= hb_tick ? 32'h0 : hb_cnt_ff + 32'h1;
         blink_cnt_ff <= bl_tick ? 32'h0 : blink_cnt_ff + 32'h1;
         if (bl_tick)
            blink_ff <= !blink_ff;
         if (hb_tick)
            heartbeat_indicator <= !heartbeat_indicator;
      end
   end

   wire [31:0] rd_mux =
      paddr == ADDR_CTRL ? {27'h0, ctrl_ff} :
      paddr == ADDR_FAULT ? {27'h0, fault_ff} :
      paddr == ADDR_STATUS ? {26'h0, state_ff, use_ext, locked_ff, sync_lvl_ff, flash_ff} :
      paddr == ADDR_EVENT ? {30'h0, event_ff} :
      paddr == ADDR_ALARM ? {28'h0, alarm_ff} :
      paddr == ADDR_AOL ? {30'h0, aol_ff} : 32'h0;

   // outputs from flops; no wait state on any access
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         flash_ff <= 1'b0;
         external_sync_fault_indicator <= 1'b0;
         day_to_twilight_fault_indicator <= 1'b0;
         twilight_to_night_fault_indicator <= 1'b0;
         lamp_degradation_indicator <= 1'b0;
         sync_fault_indicator <= 1'b0;
         comm_fault_indicator <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         // unmapped access answers with an error; its read data stays zero
         pslverr <= psel && !penable && !known;
         if (rd)
            prdata <= rd_mux;
         flash_ff <= flash_tick;
         external_sync_fault_indicator <= ext_en && (sync_lost_ev || sync_alarm
            || external_sync_fault_indicator && !locked_ff);
         day_to_twilight_fault_indicator <= forced ? blink_ff
            : fault_ff[FLT_DAY_TWI];
         twilight_to_night_fault_indicator <= forced ? blink_ff
            : fault_ff[FLT_TWI_NIGHT];
         lamp_degradation_indicator <= fault_ff[FLT_LAMP25];
         sync_fault_indicator <= fault_ff[FLT_PSU_PWR];
         comm_fault_indicator <= fault_ff[FLT_LINK] || ctrl_ff[CTRL_CFG_BAD];
      end
   end
endmodule // flash_sync_status_monitor

// ==== dv/flash_sync_checker.sv ====
// port assertions for the flash sync and status monitor
`timescale 1ns/10ps
module flash_sync_checker
   import flash_sync_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // outputs watched
   input wire logic flash_ff,
   input wire logic heartbeat_indicator,
   input wire logic lamp_degradation_indicator,
   input wire logic sync_fault_indicator,
   input wire logic comm_fault_indicator
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   wire fault_wr = psel && penable && pready && pwrite && paddr == ADDR_FAULT;
   wire lamp_bit = pwdata[FLT_LAMP25];
   wire psu_bit = pwdata[FLT_PSU_PWR];
   wire link_bit = pwdata[FLT_LINK];
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_rdy1; pready |=> !pready; endproperty
   a_rdy1: assert property (p_rdy1) else $error("ready held");
   property p_err; pslverr |-> pready && (pwrite || prdata == 32'h0); endproperty
   a_err: assert property (p_err) else $error("bad error answer");
   property p_flash; flash_ff |=> !flash_ff [*8]; endproperty
   a_flash: assert property (p_flash) else $error("flash too long");
   property p_hb; $changed(heartbeat_indicator) |=> $stable(heartbeat_indicator) [*8]; endproperty
   a_hb: assert property (p_hb) else $error("heartbeat too fast");
   property p_lamp; fault_wr |-> ##2 lamp_degradation_indicator == $past(lamp_bit, 2); endproperty
   a_lamp: assert property (p_lamp) else $error("lamp indicator wrong");
   property p_sync; fault_wr |-> ##2 sync_fault_indicator == $past(psu_bit, 2); endproperty
   a_sync: assert property (p_sync) else $error("sync indicator wrong");
   property p_comm; fault_wr && link_bit |-> ##2 comm_fault_indicator; endproperty
   a_comm: assert property (p_comm) else $error("comm indicator dark");
   property p_dark; $changed(lamp_degradation_indicator) |-> $past(fault_wr) || $past(fault_wr, 2);
   endproperty
   a_dark: assert property (p_dark) else $error("lamp changed uncaused");
   c_fault: cover property (fault_wr && lamp_bit);
   c_err: cover property (pslverr);
   c_read: cover property (psel && penable && pready && !pwrite);
endmodule // flash_sync_checker
bind flash_sync_status_monitor flash_sync_checker u_chk (
   .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .flash_ff(flash_ff), .heartbeat_indicator(heartbeat_indicator),
   .lamp_degradation_indicator(lamp_degradation_indicator),
   .sync_fault_indicator(sync_fault_indicator), .comm_fault_indicator(comm_fault_indicator));

// ==== dv/sync_pulse_source.sv ====
// pulse source standing in for the far-side sync unit
`timescale 1ns/10ps
module sync_pulse_source
#(
   parameter int PERIOD = 400,
   parameter int HIGH = 100
)
(
   // clock and supply
   input wire logic clk_sys,
   input wire logic powered,
   // sync pin
   output logic pulse
);
   int cnt_ff = 0;
   always_ff @(posedge clk_sys)
   begin
      cnt_ff <= (!powered || cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
   end
   // unpowered source drives the pin low itself and holds its count at zero
   assign pulse = powered && cnt_ff < HIGH;
endmodule // sync_pulse_source

// ==== dv/tb.sv ====
// self-checking bench for the flash sync and status monitor
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
   begin checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("ERROR %s expected %h seen %h", nm, (exp), (got)); end end
module tb
   import flash_sync_pkg::*;
;
   int checked = 0;
   int miscompares = 0;
   int flashes = 0;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic src_pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd, exp_al;
   logic pready, pslverr, err, ext_sync_in, flash_ff;
   wire [6:0] ind;
   int unsigned map [5] = '{4, 5, 6, 2, 3};
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
      if (flash_ff === 1'b1)
         flashes++;
   flash_sync_status_monitor DUT (
      .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_sync_in(ext_sync_in), .flash_ff(flash_ff), .heartbeat_indicator(ind[0]),
      .external_sync_fault_indicator(ind[1]), .day_to_twilight_fault_indicator(ind[2]),
      .twilight_to_night_fault_indicator(ind[3]), .lamp_degradation_indicator(ind[4]),
      .sync_fault_indicator(ind[5]), .comm_fault_indicator(ind[6]));
   // period far off nominal, so every pulse must be rejected
   sync_pulse_source #(.PERIOD(400), .HIGH(100)) u_src (
      .clk_sys(clk_sys), .powered(src_pwr), .pulse(ext_sync_in));
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(nm, e, rd)
   endtask
   task automatic end_of_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clk_sys);
      // no flash while held off, so the remote lights keep their own day flashing
      `CHK("flash in reset", 1'b0, flash_ff)
      arst_n <= 1'b1;
      `CHK("indicators", 7'h00, ind)
      rdchk("ctrl", ADDR_CTRL, 32'h0000_0000);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b1, ADDR_FAULT, 32'h1 << i);
         repeat (3) @(posedge clk_sys);
         `CHK("fault map", 7'h01 << map[i], ind)
      end
      apb(1'b1, ADDR_FAULT, (32'h1 << FLT_DAY_TWI) | (32'h1 << FLT_TWI_NIGHT));
      repeat (3) @(posedge clk_sys);
      `CHK("transitions", 7'h0c, ind)
      // blink phase starts dark and first turns after 250 ms, so forcing darkens both
      apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_FORCED);
      repeat (3) @(posedge clk_sys);
      `CHK("forced", 7'h00, ind)
      exp_al = (32'h1 << AL_LAMP25) | (32'h1 << AL_PSU_PWR) | (32'h1 << AL_LINK);
      rdchk("alarm", ADDR_ALARM, exp_al);
      apb(1'b1, ADDR_FAULT, 32'h0000_0000);
      apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_CFG_BAD);
      repeat (3) @(posedge clk_sys);
      `CHK("cfg bad", 7'h40, ind)
      apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_RESTART);
      rdchk("alarm kept", ADDR_ALARM, exp_al);
      rdchk("status", ADDR_STATUS, 32'h0000_0000);
      apb(1'b1, ADDR_ALARM, 32'h0000_000f);
      rdchk("alarm clr", ADDR_ALARM, 32'h0000_0000);
      apb(1'b1, 12'h0f0, 32'hffff_ffff);
      `CHK("slverr", 1'b1, err)
      rdchk("unmapped", 12'h0f0, 32'h0000_0000);
      `CHK("slverr rd", 1'b1, err)
      apb(1'b1, ADDR_AOL, 32'h0000_0002);
      apb(1'b1, ADDR_AOL, 32'h0000_0003);
      rdchk("aol", ADDR_AOL, 32'h0000_0002);
      src_pwr <= 1'b1;
      repeat (1000) @(posedge clk_sys);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      `CHK("ext off", 2'b00, rd[3:2])
      apb(1'b1, ADDR_CTRL, (32'h1 << CTRL_EXT_EN) | (32'h1 << CTRL_EXT_PWR));
      repeat (2000) @(posedge clk_sys);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      `CHK("lock", 1'b0, rd[2])
      `CHK("flashes", 0, flashes)
      apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_EXT_EN);
      repeat (3) @(posedge clk_sys);
      `CHK("sync alarm ind", 1'b1, ind[1])
      rdchk("sync alarm", ADDR_ALARM, 32'h1 << AL_SYNC);
      rdchk("config event", ADDR_EVENT, 32'h1 << EV_CONFIG);
      // power cycle mid-run: the enable must come back off
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      `CHK("ind after reset", 7'h00, ind)
      rdchk("ctrl reset", ADDR_CTRL, 32'h0000_0000);
      end_of_test();
   end
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      end_of_test();
   end
endmodule // tb

// ==== pkg/flash_sync_pkg.sv ====
// constants for the flash sync and status monitor
package flash_sync_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned SYNC_PERIOD_MS = 1500;
   localparam int unsigned SYNC_MIN_HIGH_MS = 100;
   localparam int unsigned SYNC_TOL_MS = 50;
   localparam int unsigned SYNC_LOST_PERIODS = 3;
   localparam int unsigned HEARTBEAT_MS = 500;
   localparam int unsigned BLINK_MS = 250;
   localparam int unsigned COUNTDOWN_FLASHES = 15;
   localparam int unsigned MAX_AOL = 3;
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
   // register byte offsets
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_FAULT = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [11:0] ADDR_EVENT = 12'h00c;
   localparam logic [11:0] ADDR_ALARM = 12'h010;
   localparam logic [11:0] ADDR_AOL = 12'h014;
   // control fields
   localparam int unsigned CTRL_EXT_EN = 0;
   localparam int unsigned CTRL_FORCED = 1;
   localparam int unsigned CTRL_CFG_BAD = 2;
   localparam int unsigned CTRL_RESTART = 3;
   localparam int unsigned CTRL_EXT_PWR = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   // fault inputs written by firmware
   localparam int unsigned FLT_LAMP25 = 0;
   localparam int unsigned FLT_PSU_PWR = 1;
   localparam int unsigned FLT_LINK = 2;
   localparam int unsigned FLT_DAY_TWI = 3;
   localparam int unsigned FLT_TWI_NIGHT = 4;
   // event / alarm bit positions
   localparam int unsigned EV_SYNC_LOST = 0;
   localparam int unsigned EV_CONFIG = 1;
   localparam int unsigned AL_LAMP25 = 0;
   localparam int unsigned AL_SYNC = 1;
   localparam int unsigned AL_PSU_PWR = 2;
   localparam int unsigned AL_LINK = 3;
   typedef enum logic [1:0] {ST_WARMUP, ST_COUNTDOWN, ST_RUN} run_state_e;
endpackage
